// File: pkg/cam_pkg.sv
`default_nettype none
package cam_pkg;

    // ************************************************************
    // Clock and line timing
    // ************************************************************
    localparam int SYS_CLK_MHZ   = 40;
    localparam int PIX_CLK_MHZ   = 36;
    localparam int LINE_PIX_CLKS = 780;
    // A line period is the longest a line may take, so round down
    localparam int LINE_CYCLES   = LINE_PIX_CLKS * SYS_CLK_MHZ / PIX_CLK_MHZ;
    localparam logic [9:0] LINE_LAST = 10'(LINE_CYCLES - 1);

    // Glitch filter: half the shortest legal pulse, rounded up
    localparam int FILTER_NS     = 1000;
    localparam int FILTER_CYCLES = (FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [5:0] FILTER_LAST = 6'(FILTER_CYCLES - 1);

    // ************************************************************
    // Frame geometry
    // ************************************************************
    localparam logic [9:0] ACTIVE_LINES  = 10'h1EE;
    localparam logic [9:0] FULL_FRAME    = 10'h1F4;
    localparam logic [9:0] PART_OVERHEAD = 10'h025;
    localparam logic [9:0] MIN_WINDOW    = 10'h078;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [9:0]  DEF_START   = 10'h000;
    localparam logic [9:0]  DEF_WIDTH   = 10'h1EE;
    localparam logic [15:0] DEF_SHUTTER = 16'h01F4;
    localparam logic        POL_NEG     = 1'b0;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_EXPOSE = 2'b01,
        ST_FREE   = 2'b11
    } state_e;

endpackage
`default_nettype wire

// File: pkg/line_if.sv
`timescale 1ns/100ps
`default_nettype none
interface line_if;
    logic       restart;
    logic       oneshot;
    logic [9:0] frame_lines;
    logic       running;
    logic [9:0] line_cnt;

    modport ctrl  (output restart, output oneshot, output frame_lines,
                   input running, input line_cnt);
    modport timer (input restart, input oneshot, input frame_lines,
                   output running, output line_cnt);
endinterface
`default_nettype wire

// File: core/line_timer.sv
`timescale 1ns/100ps
`default_nettype none
module line_timer
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Readout control
    line_if.timer     lif
);

    // ************************************************************
    // Line and frame counters
    // ************************************************************
    logic [9:0] sub;
    logic       sub_last;
    logic       frame_last;

    assign sub_last   = (sub == cam_pkg::LINE_LAST);
    assign frame_last = (lif.line_cnt == lif.frame_lines - 10'h001);

    // Restart wins over a frame end, so a new exposure never loses its readout
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sub          <= 10'h000;
            lif.line_cnt <= 10'h000;
            lif.running  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (lif.restart)
            begin
                sub          <= 10'h000;
                lif.line_cnt <= 10'h000;
                lif.running  <= 1'b1;
            end
            else if (lif.running)
            begin
                sub <= sub_last ? 10'h000 : sub + 10'h001;
                if (sub_last)
                begin
                    lif.line_cnt <= frame_last ? 10'h000 : lif.line_cnt + 10'h001;
                    lif.running  <= !(frame_last && lif.oneshot);
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    line_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && lif.running && !lif.restart && !sub_last |=> $stable(lif.line_cnt))
        else $error("line count moved inside a line period");
    line_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && lif.running && !lif.restart && sub_last && !frame_last
        |=> lif.line_cnt == $past(lif.line_cnt) + 10'h001 && sub == 10'h000)
        else $error("line did not advance after its period");

endmodule
`default_nettype wire

// File: core/exposure_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Full frame reads out in about 1/92s
// - Partial scan outputs only window lines
// - Trigger and restart modes never both active
// - Trigger arrives only on the CC1 input
// - Polarity selects falling or rising start edge
// - Fixed mode ends after programmed shutter time
// - Pulse mode exposes while trigger stays active
// - Frame-sync pulses arrive only on CC1
// - Restart mode exposure equals sync pulse interval
// - Line period is 780 pixel clocks
// - Polarity selectable, negative after reset
// - Window at least 120 lines, single-line steps
module exposure_ctrl
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Configuration, taken on cfg_update
    input  wire logic        cfg_update,
    input  wire logic        partial_scan,
    input  wire logic [9:0]  window_start,
    input  wire logic [9:0]  window_lines,
    input  wire logic        trig_mode_en,
    input  wire logic        trig_pulse_width,
    input  wire logic        restart_mode_en,
    input  wire logic        trig_polarity_pos,
    input  wire logic [15:0] shutter_lines,
    // Camera link control line
    input  wire logic        trigger_or_frame_sync_input,
    // Status
    output logic             exposing,
    output logic             frame_valid,
    output logic             line_valid,
    output logic [9:0]       line_number,
    output logic             mode_conflict
);

    // ************************************************************
    // Helpers and shared state
    // ************************************************************
    function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    line_if lif ();

    line_timer u_timer
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .lif     (lif)
    );

    cam_pkg::state_e state;
    cam_pkg::state_e next_state;
    logic        sync1;
    logic        sync2;
    logic        lvl;
    logic [5:0]  flt_cnt;
    logic        act_d;
    logic        partial_q;
    logic [9:0]  start_q;
    logic [9:0]  width_q;
    logic        trig_q;
    logic        pulse_q;
    logic        rst_mode_q;
    logic        pol_q;
    logic [15:0] shut_q;
    logic [9:0]  exp_sub;
    logic [15:0] exp_lines;

    // ************************************************************
    // Input synchroniser and glitch filter
    // ************************************************************
    // Only CC1 carries trigger and frame sync; no other source exists
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end
        else if (clk_en)
        begin
            sync1 <= trigger_or_frame_sync_input;
            sync2 <= sync1;
        end
    end

    // Level must hold for the filter time before it counts; costs 1us latency
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            lvl     <= 1'b1;
            flt_cnt <= 6'h00;
        end
        else if (clk_en)
        begin
            if (sync2 == lvl)
                flt_cnt <= 6'h00;
            else if (flt_cnt == cam_pkg::FILTER_LAST)
            begin
                lvl     <= sync2;
                flt_cnt <= 6'h00;
            end
            else
                flt_cnt <= flt_cnt + 6'h01;
        end
    end

    // Active level follows polarity; a start edge is inactive to active
    logic act_now;
    logic act_edge;
    assign act_now  = pol_q ? lvl : !lvl;
    assign act_edge = act_now && !act_d;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            act_d <= 1'b0;
        else if (clk_en)
            act_d <= act_now;
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Window height is clamped first, so the start can be fitted to it
    logic [9:0] next_width;
    assign next_width = clamp(window_lines, cam_pkg::MIN_WINDOW, cam_pkg::ACTIVE_LINES);

    // Restart request is dropped when trigger mode is also asked for
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            partial_q  <= 1'b0;
            start_q    <= cam_pkg::DEF_START;
            width_q    <= cam_pkg::DEF_WIDTH;
            trig_q     <= 1'b0;
            pulse_q    <= 1'b0;
            rst_mode_q <= 1'b0;
            pol_q      <= cam_pkg::POL_NEG;
            shut_q     <= cam_pkg::DEF_SHUTTER;
        end
        else if (clk_en && cfg_update)
        begin
            partial_q  <= partial_scan;
            width_q    <= next_width;
            start_q    <= clamp(window_start, 10'h000, cam_pkg::ACTIVE_LINES - next_width);
            trig_q     <= trig_mode_en;
            pulse_q    <= trig_pulse_width;
            rst_mode_q <= restart_mode_en && !trig_mode_en;
            pol_q      <= trig_polarity_pos;
            shut_q     <= (shutter_lines == 16'h0000) ? 16'h0001 : shutter_lines;
        end
    end

    // ************************************************************
    // Exposure state machine
    // ************************************************************
    logic free_mode;
    logic exp_done;
    logic start_read;
    assign free_mode = !trig_q && !rst_mode_q;
    assign exp_done  = (exp_lines == shut_q - 16'h0001) && (exp_sub == cam_pkg::LINE_LAST);
    assign lif.oneshot     = !free_mode;
    assign lif.frame_lines = partial_q ? width_q + cam_pkg::PART_OVERHEAD
                                       : cam_pkg::FULL_FRAME;
    assign lif.restart     = start_read;

    // Readout starts when an exposure ends, on each sync edge after the first in restart mode, or at entry to free run
    always_comb
    begin
        next_state = state;
        start_read = 1'b0;
        unique case (state)
            cam_pkg::ST_IDLE:
            begin
                if (free_mode)
                begin
                    next_state = cam_pkg::ST_FREE;
                    start_read = 1'b1;
                end
                else if (act_edge && (rst_mode_q || !lif.running))
                    next_state = cam_pkg::ST_EXPOSE;
            end
            cam_pkg::ST_EXPOSE:
            begin
                if (free_mode)
                    next_state = cam_pkg::ST_IDLE;
                else if (rst_mode_q)
                    start_read = act_edge;
                else if (pulse_q ? !act_now : exp_done)
                begin
                    next_state = cam_pkg::ST_IDLE;
                    start_read = 1'b1;
                end
            end
            cam_pkg::ST_FREE:
                if (!free_mode)
                    next_state = cam_pkg::ST_IDLE;
            default:
                next_state = cam_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            state <= cam_pkg::ST_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    // Fixed exposure timer, counted in whole lines from the start edge
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !clk_en)
        begin
            if (sys_rst)
            begin
                exp_sub   <= 10'h000;
                exp_lines <= 16'h0000;
            end
        end
        else if (state != cam_pkg::ST_EXPOSE)
        begin
            exp_sub   <= 10'h000;
            exp_lines <= 16'h0000;
        end
        else
        begin
            exp_sub <= (exp_sub == cam_pkg::LINE_LAST) ? 10'h000 : exp_sub + 10'h001;
            if (exp_sub == cam_pkg::LINE_LAST)
                exp_lines <= exp_lines + 16'h0001;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic       next_exposing;
    logic       next_line_valid;
    logic [9:0] lines_left;
    assign lines_left      = lif.frame_lines - lif.line_cnt;
    // Free run exposes over the last shutter lines of each frame
    assign next_exposing   = (state == cam_pkg::ST_EXPOSE) ||
                             (state == cam_pkg::ST_FREE && {6'h00, lines_left} <= shut_q);
    assign next_line_valid = lif.running && (lif.line_cnt <
                             (partial_q ? width_q : cam_pkg::ACTIVE_LINES));

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            exposing      <= 1'b0;
            frame_valid   <= 1'b0;
            line_valid    <= 1'b0;
            line_number   <= 10'h000;
            mode_conflict <= 1'b0;
        end
        else if (clk_en)
        begin
            exposing      <= next_exposing;
            frame_valid   <= lif.running;
            line_valid    <= next_line_valid;
            line_number   <= lif.line_cnt + (partial_q ? start_q : 10'h000);
            mode_conflict <= trig_mode_en && restart_mode_en && cfg_update ? 1'b1 :
                             (cfg_update ? 1'b0 : mode_conflict);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    mode_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(trig_q && rst_mode_q))
        else $error("trigger and restart modes both active");
    full_frame_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !partial_q |-> lif.frame_lines == 10'h1F4)
        else $error("full frame length wrong");
    window_min_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        width_q >= 10'h078 && start_q + width_q <= 10'h1EE)
        else $error("window outside limits");
    window_skip_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        line_valid && $past(partial_q) |-> line_number >= $past(start_q)
        && line_number < $past(start_q) + $past(width_q))
        else $error("line outside window sent");
    fixed_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && state == cam_pkg::ST_EXPOSE && trig_q && !pulse_q && exp_done
        |-> lif.restart ##1 state == cam_pkg::ST_IDLE)
        else $error("fixed exposure did not end on time");
    pulse_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && state == cam_pkg::ST_EXPOSE && trig_q && pulse_q
        |-> (act_now ? !lif.restart : lif.restart))
        else $error("pulse exposure not tied to trigger level");
    start_edge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && state == cam_pkg::ST_IDLE && trig_q && !lif.running && act_edge
        |=> state == cam_pkg::ST_EXPOSE ##1 exposing)
        else $error("active edge did not start exposure");
    sync_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && state == cam_pkg::ST_EXPOSE && rst_mode_q && act_edge
        |-> lif.restart ##2 exposing)
        else $error("frame sync did not restart exposure");
    glitch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(lvl) |-> $past(flt_cnt) == cam_pkg::FILTER_LAST)
        else $error("filtered level changed early");
    pol_reset_a: assert property (@(posedge sys_clk)
        $past(sys_rst) |-> pol_q == 1'b0)
        else $error("polarity not negative after reset");

    fixed_cov_c:   cover property (@(posedge sys_clk) disable iff (sys_rst)
        trig_q && !pulse_q && exp_done);
    restart_cov_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rst_mode_q && lif.restart);
    partial_cov_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
        partial_q && line_valid);

endmodule
`default_nettype wire

// File: tb/grabber_model.sv
`timescale 1ns/100ps
`default_nettype none
module grabber_model
(
    // Clock
    input  wire logic sys_clk,
    // Grabber polarity setting, 1 = active high
    input  wire logic pol_pos,
    // Camera control line
    output logic      cc1
);
    // ************************************************************
    // Control line drive
    // ************************************************************
    // Idles inactive; negative polarity is the power-up setting
    initial cc1 = 1'b1;

    // Park the line at the inactive level of the current polarity
    task automatic idle();
        @(negedge sys_clk);
        cc1 = ~pol_pos;
    endtask

    // Trigger or sync pulse; short requests are stretched to 2 us
    task automatic pulse(input int cycles);
        int n;
        n = (cycles < 80) ? 80 : cycles;
        @(negedge sys_clk);
        cc1 = pol_pos;
        repeat (n) @(negedge sys_clk);
        cc1 = ~pol_pos;
    endtask

    // Deliberately too short pulse, only for the noise filter scenario
    task automatic glitch(input int cycles);
        @(negedge sys_clk);
        cc1 = pol_pos;
        repeat (cycles) @(negedge sys_clk);
        cc1 = ~pol_pos;
    endtask
endmodule
`default_nettype wire

// File: tb/exposure_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module exposure_ctrl_tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        sys_clk;
    logic        sys_rst;
    logic        clk_en;
    logic        cfg_update;
    logic        partial_scan;
    logic [9:0]  window_start;
    logic [9:0]  window_lines;
    logic        trig_mode_en;
    logic        trig_pulse_width;
    logic        restart_mode_en;
    logic        trig_polarity_pos;
    logic [15:0] shutter_lines;
    logic        cc1;
    logic        pol;
    logic        exposing;
    logic        frame_valid;
    logic        line_valid;
    logic [9:0]  line_number;
    logic        mode_conflict;
    logic [9:0]  prev_ln;
    int          cyc;
    int          last_start;
    int          prev_start;
    int          mismatches;
    int          num_checks;

    exposure_ctrl exposure_ctrl_i
    (
        .sys_clk                     (sys_clk),
        .sys_rst                     (sys_rst),
        .clk_en                      (clk_en),
        .cfg_update                  (cfg_update),
        .partial_scan                (partial_scan),
        .window_start                (window_start),
        .window_lines                (window_lines),
        .trig_mode_en                (trig_mode_en),
        .trig_pulse_width            (trig_pulse_width),
        .restart_mode_en             (restart_mode_en),
        .trig_polarity_pos           (trig_polarity_pos),
        .shutter_lines               (shutter_lines),
        .trigger_or_frame_sync_input (cc1),
        .exposing                    (exposing),
        .frame_valid                 (frame_valid),
        .line_valid                  (line_valid),
        .line_number                 (line_number),
        .mode_conflict               (mode_conflict)
    );

    grabber_model grabber_model_i
    (
        .sys_clk (sys_clk),
        .pol_pos (pol),
        .cc1     (cc1)
    );

    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Readout start times; a start is line_number returning to the window start
    always @(negedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (frame_valid === 1'b1 && line_number === window_start && prev_ln !== window_start)
        begin
            prev_start <= last_start;
            last_start <= cyc;
        end
        prev_ln <= line_number;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    // Config is taken on one edge with cfg_update high
    task automatic set_cfg(input logic ps, input logic [9:0] st, input logic [9:0] wl,
                           input logic tm, input logic pw, input logic rm,
                           input logic pp, input logic [15:0] sh);
        @(negedge sys_clk);
        partial_scan      = ps;
        window_start      = st;
        window_lines      = wl;
        trig_mode_en      = tm;
        trig_pulse_width  = pw;
        restart_mode_en   = rm;
        trig_polarity_pos = pp;
        shutter_lines     = sh;
        cfg_update        = 1'b1;
        @(negedge sys_clk);
        cfg_update = 1'b0;
    endtask

    // Cycles until exposure starts, then cycles it stays high
    task automatic expo_len(output int lat, output int len);
        lat = 0;
        len = 0;
        while (exposing !== 1'b1 && lat < 200)
        begin
            @(negedge sys_clk);
            lat++;
        end
        while (exposing === 1'b1 && len < 20000)
        begin
            @(negedge sys_clk);
            len++;
        end
    endtask

    // A partial frame of 157 lines, 135962 cycles, ends just inside this bound
    task automatic wait_frame_end();
        int n;
        n = 0;
        while (frame_valid === 1'b1 && n < 140000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("frame end", 1'b0, frame_valid);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Free run after reset; a clock-enable gap stretches one line
    task automatic run_free_line();
        int n;
        n = 0;
        repeat (3) @(negedge sys_clk);
        check("frame_valid", 1'b1, frame_valid);
        check("first line", 10'h000, line_number);
        while (line_number !== 10'h001 && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
        clk_en = 1'b0;
        repeat (100) @(negedge sys_clk);
        clk_en = 1'b1;
        n = 100;
        while (line_number !== 10'h002 && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("line period", 16'(cam_pkg::LINE_CYCLES + 100), 16'(n));
    endtask

    // Both modes requested, then restart alone with a window at line 100
    task automatic run_conflict();
        set_cfg(1'b0, 10'h000, 10'h1EE, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0001);
        repeat (3) @(negedge sys_clk);
        check("mode_conflict set", 1'b1, mode_conflict);
        set_cfg(1'b1, 10'h064, 10'h078, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0001);
        repeat (3) @(negedge sys_clk);
        check("mode_conflict clear", 1'b0, mode_conflict);
    endtask

    // Sync pulses 3000 then 5000 cycles apart; readout follows the second and third
    task automatic run_restart();
        grabber_model_i.pulse(100);
        repeat (2899) @(negedge sys_clk);
        grabber_model_i.pulse(100);
        repeat (4899) @(negedge sys_clk);
        grabber_model_i.pulse(100);
        repeat (200) @(negedge sys_clk);
        check("sync interval", 16'h1388, 16'(last_start - prev_start));
        check("restart exposing", 1'b1, exposing);
        check("window first line", 10'h064, line_number);
        check("window line_valid", 1'b1, line_valid);
        repeat (cam_pkg::LINE_CYCLES) @(negedge sys_clk);
        check("window second line", 10'h065, line_number);
    endtask

    // Fixed mode, falling edge, two lines of shutter, trigger held longer
    task automatic run_fixed();
        int lat;
        int len;
        // A restart exposure only ends when its mode is left, so pass through free run
        set_cfg(1'b1, 10'h000, 10'h078, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0002);
        set_cfg(1'b1, 10'h000, 10'h078, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0002);
        wait_frame_end();
        grabber_model_i.glitch(20);
        repeat (100) @(negedge sys_clk);
        check("glitch ignored", 1'b0, exposing);
        fork
            grabber_model_i.pulse(3000);
            expo_len(lat, len);
        join
        check("fixed start", 1'b1, 16'(lat <= 60));
        check("fixed length", 16'(2 * cam_pkg::LINE_CYCLES), 16'(len));
        check("readout after exposure", 1'b1, frame_valid);
    endtask

    // Pulse-width mode, rising edge; polarity moved while readout runs
    task automatic run_pulse();
        int lat;
        int len;
        pol = 1'b1;
        grabber_model_i.idle();
        set_cfg(1'b1, 10'h000, 10'h078, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0002);
        wait_frame_end();
        fork
            grabber_model_i.pulse(2000);
            expo_len(lat, len);
        join
        check("pulse start", 1'b1, 16'(lat <= 60));
        check("pulse length", 1'b1, 16'(len >= 1998 && len <= 2002));
    endtask

    // Reset in mid-run clears the outputs and brings back free run
    task automatic run_reset();
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("exposing after reset", 1'b0, exposing);
        check("line_valid after reset", 1'b0, line_valid);
        check("mode_conflict after reset", 1'b0, mode_conflict);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("frame after reset", 1'b1, frame_valid);
        check("line after reset", 10'h000, line_number);
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial
    begin
        {sys_rst, clk_en, cfg_update, pol} = 4'hC;
        {partial_scan, window_start, window_lines} = 21'h0;
        {trig_mode_en, trig_pulse_width, restart_mode_en, trig_polarity_pos} = 4'h0;
        shutter_lines = 16'h0001;
        {mismatches, num_checks} = '0;
        repeat (5) @(negedge sys_clk);
        check("exposing in reset", 1'b0, exposing);
        check("frame_valid in reset", 1'b0, frame_valid);
        sys_rst = 1'b0;
        run_free_line();
        run_conflict();
        run_restart();
        run_fixed();
        run_pulse();
        run_reset();
        close_out();
    end

    // Whole sequence needs about 300k cycles
    initial
    begin
        repeat (400000) @(posedge sys_clk);
        mismatches++;
        $display("unexpected watchdog: expected finish, seen hang");
        close_out();
    end
endmodule
`default_nettype wire
